// file: interrupt_vector_map.v
// interrupt vector map for requests 39 to 63 with control register and AHB-Lite slave
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "irq_map_consts.vh"

module interrupt_vector_map #(
    parameter [31:0] SRC_PRESENT = `FLAG_IMPL_MASK
) (
    input  wire        MCLK_IN,
    input  wire        RST_B_IN,
    input  wire        HSEL_IN,
    input  wire [31:0] HADDR_IN,
    input  wire [1:0]  HTRANS_IN,
    input  wire        HWRITE_IN,
    input  wire [2:0]  HSIZE_IN,
    input  wire [31:0] HWDATA_IN,
    input  wire        HREADY_IN,
    output wire [31:0] HRDATA_OUT,
    output wire        HREADYOUT_OUT,
    output wire        HRESP_OUT,
    input  wire [24:0] SRC_REQ_IN,
    input  wire [4:0]  EXT_IRQ_IN,
    output wire [4:0]  EXT_EDGE_OUT,
    output wire        IRQ_VALID_OUT,
    output wire [5:0]  IRQ_VECTOR_OUT,
    output wire [2:0]  IRQ_PRIORITY_OUT,
    output wire [1:0]  IRQ_SUBPRIO_OUT,
    output wire        MULTI_VECTOR_OUT,
    output wire        PROX_START_OUT,
    output wire        INT_OUT
);

    // group mask of the flag bits that share one vector
    function [31:0] vec_mask;
        input [3:0] v;
        begin
            case (v)
                4'h0:    vec_mask = `VEC_MASK_32;
                4'h1:    vec_mask = `VEC_MASK_33;
                4'h2:    vec_mask = `VEC_MASK_34;
                4'h3:    vec_mask = `VEC_MASK_35;
                4'h4:    vec_mask = `VEC_MASK_36;
                4'h5:    vec_mask = `VEC_MASK_37;
                4'h6:    vec_mask = `VEC_MASK_38;
                4'h7:    vec_mask = `VEC_MASK_39;
                4'h8:    vec_mask = `VEC_MASK_40;
                4'h9:    vec_mask = `VEC_MASK_41;
                4'hA:    vec_mask = `VEC_MASK_42;
                4'hB:    vec_mask = `VEC_MASK_43;
                default: vec_mask = `ZERO_WORD;
            endcase
        end
    endfunction

    // priority and sub-priority lane of one 32-bit priority word
    function [4:0] lane_field;
        input [31:0] word;
        input [1:0]  lane;
        reg   [31:0] shifted_v;
        reg   [7:0]  byte_v;
        begin
            // shift the wanted lane down, then keep its low byte on purpose
            shifted_v = word >> (lane * `LANE_WIDTH);
            byte_v = shifted_v[7:0];
            lane_field = byte_v[`PRIO_MSB:0];
        end
    endfunction

    reg  [31:0] control_r;
    reg  [31:0] flag_r;
    reg  [31:0] flag_nxt;
    reg  [31:0] enable_r;
    reg  [31:0] prio_r [0:2];
    reg  [5:0]  evt_status_r;
    reg  [5:0]  evt_status_nxt;
    reg  [5:0]  evt_mask_r;
    reg  [31:0] req_prev_r;
    reg  [4:0]  ext_prev_r;
    reg  [4:0]  ext_edge_r;
    reg  [4:0]  ext_edge_nxt;
    reg         irq_valid_r;
    reg  [5:0]  irq_vector_r;
    reg  [2:0]  irq_prio_r;
    reg  [1:0]  irq_sub_r;
    reg         prox_start_r;
    reg         int_r;
    reg  [31:0] hrdata_r;
    reg         hreadyout_r;
    reg         hresp_r;
    reg         wr_pend_r;
    reg         rd_pend_r;
    reg  [7:0]  addr_r;
    reg  [31:0] rd_mux;
    reg         best_valid;
    reg  [3:0]  best_vec;
    reg  [4:0]  best_field;
    reg  [4:0]  cand;
    reg  [31:0] pend;
    integer     i;

    wire        phase_ok  = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
    wire [31:0] req_word  = {SRC_REQ_IN, {`FIRST_FLAG_BIT{1'b0}}} & SRC_PRESENT;
    wire [31:0] req_rise  = req_word & ~req_prev_r;
    wire [2:0]  proximity_timer_threshold       = control_r[`TPC_MSB:`TPC_LSB];
    wire        wr_now    = wr_pend_r;
    wire [4:0]  ext_pol   = control_r[`POL_MSB:0];

    // persistent sources set their flag while their level is high, dma channels catch the rising edge
    wire [31:0] flag_set  = (req_word & `PERSIST_MASK) |
                            (req_rise & ~`PERSIST_MASK);

    always @* begin
        flag_nxt = flag_r;
        if (wr_now && addr_r == `OFS_FLAG_ONE) begin
            flag_nxt = HWDATA_IN & SRC_PRESENT;
        end
        flag_nxt = flag_nxt | flag_set;
    end

    always @* begin
        for (i = 0; i < 5; i = i + 1) begin
            ext_edge_nxt[i] = ext_pol[i] ? (EXT_IRQ_IN[i] & ~ext_prev_r[i])
                                         : (~EXT_IRQ_IN[i] & ext_prev_r[i]);
        end
    end

    // pick the pending vector with highest priority, then sub-priority; ties keep the lower vector
    always @* begin
        best_valid = 1'b0;
        best_vec   = 4'h0;
        best_field = 5'h00;
        cand       = 5'h00;
        pend       = flag_r & enable_r & SRC_PRESENT;
        for (i = 0; i < `VEC_COUNT; i = i + 1) begin
            cand = lane_field(prio_r[i / 4], i[1:0]);
            if ((|(pend & vec_mask(i[3:0]))) && cand[`PRIO_MSB:`PRIO_LSB] != 3'h0 &&
                (!best_valid || cand > best_field)) begin
                best_valid = 1'b1;
                best_vec   = i[3:0];
                best_field = cand;
            end
        end
    end

    always @* begin
        if (addr_r == `OFS_CONTROL) begin
            rd_mux = control_r;
        end else if (addr_r == `OFS_FLAG_ONE) begin
            rd_mux = flag_r;
        end else if (addr_r == `OFS_ENABLE_ONE) begin
            rd_mux = enable_r;
        end else if (addr_r == `OFS_PRIO_EIGHT) begin
            rd_mux = prio_r[0];
        end else if (addr_r == `OFS_PRIO_NINE) begin
            rd_mux = prio_r[1];
        end else if (addr_r == `OFS_PRIO_TEN) begin
            rd_mux = prio_r[2];
        end else if (addr_r == `OFS_EVT_STATUS) begin
            rd_mux = {26'h000_0000, evt_status_r};
        end else if (addr_r == `OFS_EVT_MASK) begin
            rd_mux = {26'h000_0000, evt_mask_r};
        end else begin
            rd_mux = `ZERO_WORD;
        end
    end

    wire prox_fire = best_valid & ~irq_valid_r & (proximity_timer_threshold != 3'h0) &
                     (best_field[`PRIO_MSB:`PRIO_LSB] <= proximity_timer_threshold);

    // sticky event bits: a new event wins over a write-one-to-clear in the same cycle
    always @* begin
        evt_status_nxt = evt_status_r;
        if (wr_now && addr_r == `OFS_EVT_STATUS) begin
            evt_status_nxt = evt_status_r & ~HWDATA_IN[5:0];
        end
        evt_status_nxt = evt_status_nxt | {prox_fire, ext_edge_nxt};
    end

    // bus slave: writes are zero-wait, reads take one wait state
    always @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            wr_pend_r   <= 1'b0;
            rd_pend_r   <= 1'b0;
            addr_r      <= 8'h00;
            hrdata_r    <= `ZERO_WORD;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
            if (rd_pend_r) begin
                hrdata_r    <= rd_mux;
                hreadyout_r <= 1'b1;
                rd_pend_r   <= 1'b0;
                wr_pend_r   <= 1'b0;
            end else begin
                wr_pend_r <= phase_ok & HWRITE_IN;
                rd_pend_r <= phase_ok & ~HWRITE_IN;
                if (phase_ok) begin
                    addr_r <= HADDR_IN[7:0];
                end
                hreadyout_r <= ~(phase_ok & ~HWRITE_IN);
            end
        end
    end

    always @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            control_r    <= `ZERO_WORD;
            flag_r       <= `ZERO_WORD;
            enable_r     <= `ZERO_WORD;
            prio_r[0]    <= `ZERO_WORD;
            prio_r[1]    <= `ZERO_WORD;
            prio_r[2]    <= `ZERO_WORD;
            evt_status_r <= 6'h00;
            evt_mask_r   <= 6'h00;
            req_prev_r   <= `ZERO_WORD;
            ext_prev_r   <= 5'h00;
            ext_edge_r   <= 5'h00;
        end else begin
            flag_r       <= flag_nxt;
            evt_status_r <= evt_status_nxt;
            req_prev_r   <= req_word;
            ext_prev_r   <= EXT_IRQ_IN;
            ext_edge_r   <= ext_edge_nxt;
            if (wr_now) begin
                if (addr_r == `OFS_CONTROL) begin
                    control_r <= HWDATA_IN & `CONTROL_MASK;
                end else if (addr_r == `OFS_ENABLE_ONE) begin
                    enable_r <= HWDATA_IN & SRC_PRESENT;
                end else if (addr_r == `OFS_PRIO_EIGHT) begin
                    prio_r[0] <= HWDATA_IN & `PRIO_WORD_MASK;
                end else if (addr_r == `OFS_PRIO_NINE) begin
                    prio_r[1] <= HWDATA_IN & `PRIO_WORD_MASK;
                end else if (addr_r == `OFS_PRIO_TEN) begin
                    prio_r[2] <= HWDATA_IN & `PRIO_WORD_MASK;
                end else if (addr_r == `OFS_EVT_MASK) begin
                    evt_mask_r <= HWDATA_IN[5:0];
                end
            end
        end
    end

    // core side: single-vectored mode always hands out vector zero
    always @(posedge MCLK_IN) begin
        if (!RST_B_IN) begin
            irq_valid_r  <= 1'b0;
            irq_vector_r <= 6'h00;
            irq_prio_r   <= 3'h0;
            irq_sub_r    <= 2'h0;
            prox_start_r <= 1'b0;
            int_r        <= 1'b0;
        end else begin
            irq_valid_r  <= best_valid;
            irq_vector_r <= control_r[`MULTI_VECTOR_SELECT_BIT] ? (`VEC_BASE + {2'b00, best_vec}) : 6'h00;
            irq_prio_r   <= best_field[`PRIO_MSB:`PRIO_LSB];
            irq_sub_r    <= best_field[`SUB_MSB:0];
            prox_start_r <= prox_fire;
            int_r        <= |(evt_status_nxt & evt_mask_r);
        end
    end

    assign HRDATA_OUT       = hrdata_r;
    assign HREADYOUT_OUT    = hreadyout_r;
    assign HRESP_OUT        = hresp_r;
    assign EXT_EDGE_OUT     = ext_edge_r;
    assign IRQ_VALID_OUT    = irq_valid_r;
    assign IRQ_VECTOR_OUT   = irq_vector_r;
    assign IRQ_PRIORITY_OUT = irq_prio_r;
    assign IRQ_SUBPRIO_OUT  = irq_sub_r;
    assign MULTI_VECTOR_OUT = control_r[`MULTI_VECTOR_SELECT_BIT];
    assign PROX_START_OUT   = prox_start_r;
    assign INT_OUT          = int_r;

endmodule // interrupt_vector_map
`default_nettype wire

// file: irq_map_consts.vh
// constants for the interrupt vector map block, requests 39 to 63
// Contract
// - first uart fault/receive/transfer are requests 39-41, vector 32, flag bits 7-9.
// - each vector has 3-bit priority and 2-bit sub-priority, four lanes per word.
// - first i2c collision/slave/master are requests 42-44, vector 33, bits 10-12.
// - port a/b/c change are requests 45-47, vector 34, bits 13-15.
// - parallel port event and error are requests 48-49, vector 35, bits 16-17.
// - second spi requests 50-52, vector 36, bits 18-20, priority word nine lane 0.
// - second uart requests 53-55, vector 37, bits 21-23.
// - second i2c requests 56-58 vector 38 bits 24-26; charge unit 59 vector 39 bit 27.
// - dma channels are requests 60-63, vectors 40-43, bits 28-31, priority word ten.
// - requests 39-59 are persistent, dma requests are not.
// - control register: vector mode bit 12, timer field 10:8, polarities 4:0.
// - omitted sources have flag, enable and priority positions without function.
// - vector mode bit one selects multi-vectored, zero single-vectored.
// - timer starts for priority at or below the field; zero disables it.
// - external interrupt edge is rising when polarity one, falling when zero.
// - a request sets its flag; the enable bit permits the interrupt.
`ifndef IRQ_MAP_CONSTS_VH
`define IRQ_MAP_CONSTS_VH

`define OFS_CONTROL     8'h00
`define OFS_FLAG_ONE    8'h10
`define OFS_ENABLE_ONE  8'h20
`define OFS_PRIO_EIGHT  8'h30
`define OFS_PRIO_NINE   8'h40
`define OFS_PRIO_TEN    8'h50
`define OFS_EVT_STATUS  8'h60
`define OFS_EVT_MASK    8'h70

`define ZERO_WORD       32'h0000_0000
`define CONTROL_MASK    32'h0000_171F
`define PRIO_WORD_MASK  32'h1F1F_1F1F
`define FLAG_IMPL_MASK  32'hFFFF_FF80
`define PERSIST_MASK    32'h0FFF_FF80
`define FIRST_FLAG_BIT  7

`define MULTI_VECTOR_SELECT_BIT        12
`define TPC_MSB         10
`define TPC_LSB         8
`define POL_MSB         4
`define LANE_WIDTH      8
`define PRIO_MSB        4
`define PRIO_LSB        2
`define SUB_MSB         1

`define VEC_BASE        6'h20
`define VEC_COUNT       12
`define VEC_MASK_32     32'h0000_0380
`define VEC_MASK_33     32'h0000_1C00
`define VEC_MASK_34     32'h0000_E000
`define VEC_MASK_35     32'h0003_0000
`define VEC_MASK_36     32'h001C_0000
`define VEC_MASK_37     32'h00E0_0000
`define VEC_MASK_38     32'h0700_0000
`define VEC_MASK_39     32'h0800_0000
`define VEC_MASK_40     32'h1000_0000
`define VEC_MASK_41     32'h2000_0000
`define VEC_MASK_42     32'h4000_0000
`define VEC_MASK_43     32'h8000_0000

`define EVT_PROX_BIT    5

`endif

// file: irq_map_end.v
`timescale 1ns/100ps

// file: irq_src_model.sv
// peripheral request sources: levels held until dropped
`timescale 1ns/100ps
`default_nettype none
module irq_src_model (
    input  wire logic        clk_in,
    output var  logic [24:0] req_out
);
    initial req_out = 25'h000_0000;
    // a held level keeps persistent flags set; dma flags see only the rise
    task raise(input int k);
        @(posedge clk_in);
        req_out[k] <= 1'b1;
    endtask
    task drop(input int k);
        @(posedge clk_in);
        req_out[k] <= 1'b0;
    endtask
endmodule // irq_src_model
`default_nettype wire

// file: ivm_sva.sv
// port assertions for the interrupt vector map
`timescale 1ns/100ps
`default_nettype none
module ivm_sva (
    input wire        MCLK_IN,
    input wire        RST_B_IN,
    input wire        HSEL_IN,
    input wire [1:0]  HTRANS_IN,
    input wire        HWRITE_IN,
    input wire        HREADY_IN,
    input wire        HREADYOUT_OUT,
    input wire        HRESP_OUT,
    input wire [4:0]  EXT_IRQ_IN,
    input wire [4:0]  EXT_EDGE_OUT,
    input wire        IRQ_VALID_OUT,
    input wire [5:0]  IRQ_VECTOR_OUT,
    input wire [2:0]  IRQ_PRIORITY_OUT,
    input wire        MULTI_VECTOR_OUT,
    input wire        PROX_START_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_B_IN);
    sequence taken_s;
        HSEL_IN && HTRANS_IN[1] && HREADY_IN && HREADYOUT_OUT;
    endsequence
    sequence one_wait_s;
        !HREADYOUT_OUT ##1 HREADYOUT_OUT;
    endsequence
    read_wait_a: assert property (taken_s ##0 !HWRITE_IN |=> one_wait_s)
        else $error("read wait is not one cycle");
    write_nowait_a: assert property (taken_s ##0 HWRITE_IN |=> HREADYOUT_OUT)
        else $error("write was stalled");
    resp_okay_a: assert property (HRESP_OUT == 1'b0)
        else $error("response not okay");
    single_vector_a: assert property (
        IRQ_VALID_OUT && !MULTI_VECTOR_OUT && !$past(MULTI_VECTOR_OUT) |-> IRQ_VECTOR_OUT == 6'h00)
        else $error("single mode vector not zero");
    multi_range_a: assert property (
        IRQ_VALID_OUT && MULTI_VECTOR_OUT && $past(MULTI_VECTOR_OUT) |-> IRQ_VECTOR_OUT inside {[6'h20:6'h2B]})
        else $error("vector out of range");
    valid_prio_a: assert property (IRQ_VALID_OUT |-> IRQ_PRIORITY_OUT != 3'h0)
        else $error("zero priority presented");
    prox_pulse_a: assert property (PROX_START_OUT |=> !PROX_START_OUT)
        else $error("proximity start longer than one cycle");
    edge_cause_a: assert property (
        |EXT_EDGE_OUT |-> (EXT_EDGE_OUT & ~($past(EXT_IRQ_IN) ^ $past(EXT_IRQ_IN, 2))) == 5'h00)
        else $error("edge pulse without pin change");
    edge_single_a: assert property (|EXT_EDGE_OUT |=> (EXT_EDGE_OUT & $past(EXT_EDGE_OUT)) == 5'h00)
        else $error("edge pulse repeated");
endmodule // ivm_sva
bind interrupt_vector_map ivm_sva u_ivm_sva (.MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN), .HSEL_IN(HSEL_IN),
    .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN), .HREADYOUT_OUT(HREADYOUT_OUT),
    .HRESP_OUT(HRESP_OUT), .EXT_IRQ_IN(EXT_IRQ_IN), .EXT_EDGE_OUT(EXT_EDGE_OUT), .IRQ_VALID_OUT(IRQ_VALID_OUT),
    .IRQ_VECTOR_OUT(IRQ_VECTOR_OUT), .IRQ_PRIORITY_OUT(IRQ_PRIORITY_OUT), .MULTI_VECTOR_OUT(MULTI_VECTOR_OUT),
    .PROX_START_OUT(PROX_START_OUT));
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the interrupt vector map
`timescale 1ns/100ps
`default_nettype none
`include "irq_map_consts.vh"
module tb_top;
    logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, q;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2;
    wire         hresp;
    logic [4:0]  ext = 5'h00, seen;
    logic [11:0] snap;
    logic        pseen, int_s;
    wire  [31:0] hrdata;
    wire  [24:0] req;
    wire  [5:0]  vec;
    wire  [4:0]  ext_edge;
    wire  [2:0]  prio;
    wire  [1:0]  sub;
    wire         hready, valid, multi_vector_select, prox, irq;
    int          mismatches = 0, n_checks = 0;
    int          vec_tab [25] = '{32, 32, 32, 33, 33, 33, 34, 34, 34, 35, 35, 36, 36, 36, 37, 37, 37,
                                  38, 38, 38, 39, 40, 41, 42, 43};
    always #4 clk = ~clk;
    irq_src_model u_irq_src_model (.clk_in(clk), .req_out(req));
    interrupt_vector_map u_interrupt_vector_map (.MCLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .SRC_REQ_IN(req), .EXT_IRQ_IN(ext),
        .EXT_EDGE_OUT(ext_edge), .IRQ_VALID_OUT(valid), .IRQ_VECTOR_OUT(vec), .IRQ_PRIORITY_OUT(prio),
        .IRQ_SUBPRIO_OUT(sub), .MULTI_VECTOR_OUT(multi_vector_select), .PROX_START_OUT(prox), .INT_OUT(irq));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // settled values are taken at the falling edge before each sampling edge
    task automatic wait_rdy;
        logic r;
        do begin
            @(negedge clk);
            r = hready;
            q = hrdata;
            @(posedge clk);
        end while (r !== 1'b1);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00; hwdata <= d;
        wait_rdy();
        chk("okay response", 0, hresp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        chk(nm, e, q);
    endtask
    task automatic cyc(input int n);
        repeat (n) begin
            @(negedge clk);
            snap = {valid, vec, prio, sub}; seen |= ext_edge; pseen |= prox; int_s = irq;
            @(posedge clk);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd("control reset", `OFS_CONTROL, 32'h0000_0000);
        wr(`OFS_CONTROL, 32'hFFFF_FFFF);
        rd("control bits", `OFS_CONTROL, 32'h0000_171F);
        rd("unmapped", 8'h0C, 32'h0000_0000);
        wr(`OFS_CONTROL, 32'h0000_1000);
        wr(`OFS_ENABLE_ONE, 32'hFFFF_FF80);
        for (int k = 0; k < 25; k++) begin
            for (int w = 0; w < 3; w++)
                wr(`OFS_PRIO_EIGHT + 8'(16 * w), (w == (vec_tab[k] - 32) / 4) ?
                   32'h0000_000E << (8 * ((vec_tab[k] - 32) % 4)) : 32'h0000_0000);
            u_irq_src_model.raise(k);
            cyc(3);
            chk("vector", {1'b1, 6'(vec_tab[k]), 3'h3, 2'h2}, snap);
            rd("flag set", `OFS_FLAG_ONE, 32'h0000_0080 << k);
            wr(`OFS_FLAG_ONE, 32'h0000_0000);
            rd("flag cleared", `OFS_FLAG_ONE, (k < 21) ? 32'h0000_0080 << k : 32'h0000_0000);
            u_irq_src_model.drop(k);
            wr(`OFS_FLAG_ONE, 32'h0000_0000);
            cyc(2);
            chk("idle", 0, snap[11]);
        end
        wr(`OFS_PRIO_EIGHT, 32'h0000_0008);
        wr(`OFS_PRIO_TEN, 32'h1400_0000);
        u_irq_src_model.raise(0);
        u_irq_src_model.raise(24);
        cyc(3);
        chk("arbitrate", {1'b1, 6'h2B, 3'h5, 2'h0}, snap);
        wr(`OFS_ENABLE_ONE, 32'h7FFF_FF80);
        cyc(3);
        chk("enable gate", {1'b1, 6'h20, 3'h2, 2'h0}, snap);
        wr(`OFS_CONTROL, 32'h0000_0000);
        cyc(3);
        chk("single mode", {1'b1, 6'h00, 3'h2, 2'h0, 1'b0}, {snap, multi_vector_select});
        u_irq_src_model.drop(0);
        u_irq_src_model.drop(24);
        wr(`OFS_FLAG_ONE, 32'h0000_0000);
        wr(`OFS_PRIO_EIGHT, 32'h0000_000C);
        for (int t = 3; t >= 0; t--) begin
            wr(`OFS_CONTROL, 32'h0000_1000 | (t << 8));
            pseen = 1'b0;
            u_irq_src_model.raise(0);
            cyc(4);
            chk("prox start", t >= 3, pseen);
            u_irq_src_model.drop(0);
            wr(`OFS_FLAG_ONE, 32'h0000_0000);
            cyc(2);
        end
        wr(`OFS_EVT_STATUS, 32'h0000_003F);
        wr(`OFS_CONTROL, 32'h0000_1015);
        seen = 5'h00;
        ext <= 5'h1F;
        cyc(4);
        chk("rising edges", 5'h15, seen);
        seen = 5'h00;
        ext <= 5'h00;
        cyc(4);
        chk("falling edges", 5'h0A, seen);
        rd("event status", `OFS_EVT_STATUS, 32'h0000_001F);
        chk("masked irq", 0, int_s);
        wr(`OFS_EVT_MASK, 32'h0000_003F);
        cyc(2);
        chk("irq raised", 1, int_s);
        wr(`OFS_EVT_STATUS, 32'h0000_001F);
        cyc(2);
        chk("irq cleared", 0, int_s);
        rd("status cleared", `OFS_EVT_STATUS, 32'h0000_0000);
        // second reset in mid-run must drop valid and bring control and enable back to zero
        wr(`OFS_CONTROL, 32'h0000_1015);
        wr(`OFS_ENABLE_ONE, 32'hFFFF_FF80);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        cyc(1);
        chk("valid after reset", 0, snap[11]);
        rd("control after reset", `OFS_CONTROL, 32'h0000_0000);
        rd("enable after reset", `OFS_ENABLE_ONE, 32'h0000_0000);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
